/* hdl/pom_top.sv */
// pom_top: output source mux and driver enable for pin 4, with its
// control register on APB.
// assumes status inputs come from logic on I_SYS_CLK; pin level and
// enable are registered, so the pin follows the mux one cycle later.
//
// Function
// - source field bits 4:2: rx ports 0-3, status, tx port 0
// - select field bits 7:5; any source 0xx is a receive port
// - rx source, select 000-011 drive forwarded remote pins 0-3
// - rx source, select 100 gives lock, 101 gives pass
// - rx source, select 110 frame valid, 111 line valid
// - status source, select 000 drives the software value bit
// - status source, select 001 ORs lock of enabled rx ports
// - status source, 010 and 011 AND pass of enabled rx ports
// - status source, 100 frame sync; 101-111 reserved
// - tx source, 000 ANDs, 001 ORs chosen rx port status
// - tx source, 010 frame being sent, 011 line being sent
// - tx source, 100 synchronized, 101 tx interrupt, 110-111 reserved
// - bit 1 gives the level for the software value selection
// - bit 0 clear disables the pin driver, set enables it
module pom_top import pom_pkg::*; (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic [3:0]  I_PSTRB,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	input  wire logic [15:0] I_RX_REMOTE_PIN,
	input  wire logic [3:0]  I_RX_LOCK,
	input  wire logic [3:0]  I_RX_PASS,
	input  wire logic [3:0]  I_RX_FRAME_VALID,
	input  wire logic [3:0]  I_RX_LINE_VALID,
	input  wire logic [3:0]  I_RX_PORT_EN,
	input  wire logic        I_FRAME_SYNC_PULSE,
	input  wire logic [3:0]  I_TX_RX_SEL,
	input  wire logic        I_TX_FRAME_ACTIVE,
	input  wire logic        I_TX_LINE_ACTIVE,
	input  wire logic        I_TX_SYNCED,
	input  wire logic        I_TX_IRQ,
	output logic             O_PIN4,
	output logic             O_PIN4_DRV_N
);
	pom_ctl_if cfg ();

	// ------------------------------------------------------------
	// register file and source mux
	// ------------------------------------------------------------
	pom_regs u_regs (
		.i_clk     (I_SYS_CLK),
		.i_rst     (I_RST),
		.i_psel    (I_PSEL),
		.i_penable (I_PENABLE),
		.i_pwrite  (I_PWRITE),
		.i_paddr   (I_PADDR),
		.i_pwdata  (I_PWDATA),
		.i_pstrb   (I_PSTRB),
		.o_prdata  (O_PRDATA),
		.o_pready  (O_PREADY),
		.o_pslverr (O_PSLVERR),
		.cfg       (cfg.regs)
	);

	pom_mux u_mux (
		.i_rx_remote_pin    (I_RX_REMOTE_PIN),
		.i_rx_lock          (I_RX_LOCK),
		.i_rx_pass          (I_RX_PASS),
		.i_rx_frame_valid   (I_RX_FRAME_VALID),
		.i_rx_line_valid    (I_RX_LINE_VALID),
		.i_rx_port_en       (I_RX_PORT_EN),
		.i_frame_sync_pulse (I_FRAME_SYNC_PULSE),
		.i_tx_rx_sel        (I_TX_RX_SEL),
		.i_tx_frame_active  (I_TX_FRAME_ACTIVE),
		.i_tx_line_active   (I_TX_LINE_ACTIVE),
		.i_tx_synced        (I_TX_SYNCED),
		.i_tx_irq           (I_TX_IRQ),
		.cfg                (cfg.mux)
	);

	// ------------------------------------------------------------
	// pin driver
	// ------------------------------------------------------------
	// registered level and active-low enable, driver off in reset
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_PIN4       <= POM_PIN_RST;
			O_PIN4_DRV_N <= POM_DRV_N_RST;
		end else begin
			O_PIN4       <= cfg.level;
			O_PIN4_DRV_N <= ~cfg.drive_en;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);

	// reference terms for the checks
	wire       a_rx    = ~cfg.src[2];
	wire       a_dev   = (cfg.src == POM_SRC_DEV);
	wire       a_tx    = (cfg.src == POM_SRC_TX0);
	wire [3:0] a_pidx  = {cfg.src[1:0], cfg.sel[1:0]};
	wire       a_rpin  = I_RX_REMOTE_PIN[a_pidx];
	wire       a_lock  = I_RX_LOCK[cfg.src[1:0]];
	wire       a_pass  = I_RX_PASS[cfg.src[1:0]];
	wire       a_fv    = I_RX_FRAME_VALID[cfg.src[1:0]];
	wire       a_lv    = I_RX_LINE_VALID[cfg.src[1:0]];
	wire [3:0] a_lk_en = I_RX_LOCK & I_RX_PORT_EN;
	wire [3:0] a_ps_en = I_RX_PASS & I_RX_PORT_EN;
	wire [3:0] a_ps_tx = I_RX_PASS & I_TX_RX_SEL;
	wire       a_bad   = (cfg.src == POM_SRC_RSV5) ||
	                     (cfg.src == POM_SRC_RSV7);
	wire [7:0] a_ctl   = {cfg.sel, cfg.src, cfg.local_val, cfg.drive_en};

	// apb steps
	sequence s_ctl_write;
		I_PSEL && I_PENABLE && I_PWRITE &&
		(I_PADDR == POM_ADDR_CTL) && I_PSTRB[0];
	endsequence

	sequence s_ctl_read;
		I_PSEL && !I_PENABLE && !I_PWRITE && (I_PADDR == POM_ADDR_CTL)
		##1 I_PSEL && I_PENABLE;
	endsequence

	sequence s_enable_write;
		s_ctl_write and I_PWDATA[POM_EN_BIT];
	endsequence

	// reserved sources drive low
	src_decode_a : assert property (
		a_bad |-> cfg.rsv ##1 !O_PIN4)
		else $error("reserved source did not drive low");

	// control write reaches the fields
	ctl_write_a : assert property (
		s_ctl_write |=> a_ctl == $past(I_PWDATA[7:0]))
		else $error("control write not stored");

	ctl_readback_a : assert property (
		s_ctl_read |-> O_PRDATA == {24'h000000, $past(a_ctl)})
		else $error("control readback wrong");

	rx_remote_pin_a : assert property (
		a_rx && !cfg.sel[2] |=> O_PIN4 == $past(a_rpin))
		else $error("forwarded remote pin not on pin");

	rx_lock_a : assert property (
		a_rx && cfg.sel == POM_RX_LOCK |=> O_PIN4 == $past(a_lock))
		else $error("rx lock not on pin");

	rx_pass_only_a : assert property (
		a_rx && cfg.sel == POM_RX_PASS |=> O_PIN4 == $past(a_pass))
		else $error("rx pass not on pin");

	rx_valid_a : assert property (
		a_rx && cfg.sel[2:1] == 2'h3 |=>
		O_PIN4 == ($past(cfg.sel[0]) ? $past(a_lv) : $past(a_fv)))
		else $error("rx frame or line valid not on pin");

	dev_value_a : assert property (
		a_dev && cfg.sel == POM_DEV_VAL |=> O_PIN4 == $past(cfg.local_val))
		else $error("software value not on pin");

	dev_lock_or_a : assert property (
		a_dev && cfg.sel == POM_DEV_LOCK_OR |=> O_PIN4 == $past(|a_lk_en))
		else $error("lock OR wrong");

	dev_pass_and_a : assert property (
		a_dev && cfg.sel[2:1] == 2'h1 |=>
		O_PIN4 == ($past(|I_RX_PORT_EN) && $past(a_ps_en == I_RX_PORT_EN)))
		else $error("pass AND wrong");

	dev_fsync_a : assert property (
		a_dev && cfg.sel == POM_DEV_FSYNC |=> O_PIN4 == $past(I_FRAME_SYNC_PULSE))
		else $error("frame sync not on pin");

	dev_reserved_a : assert property (
		a_dev && cfg.sel > POM_DEV_FSYNC |-> cfg.rsv ##1 !O_PIN4)
		else $error("reserved status select not low");

	tx_pass_a : assert property (
		a_tx && cfg.sel[2:1] == 2'h0 |=> O_PIN4 == ($past(cfg.sel[0]) ?
		$past(|a_ps_tx) :
		($past(|I_TX_RX_SEL) && $past(a_ps_tx == I_TX_RX_SEL))))
		else $error("tx pass AND or OR wrong");

	tx_video_a : assert property (
		a_tx && cfg.sel[2:1] == 2'h1 |=> O_PIN4 == ($past(cfg.sel[0]) ?
		$past(I_TX_LINE_ACTIVE) : $past(I_TX_FRAME_ACTIVE)))
		else $error("tx frame or line active not on pin");

	tx_sync_irq_a : assert property (
		a_tx && cfg.sel[2:1] == 2'h2 |=> O_PIN4 == ($past(cfg.sel[0]) ?
		$past(I_TX_IRQ) : $past(I_TX_SYNCED)))
		else $error("tx synced or interrupt not on pin");

	tx_reserved_a : assert property (
		a_tx && cfg.sel[2:1] == 2'h3 |-> cfg.rsv ##1 !O_PIN4)
		else $error("reserved tx select not low");

	value_write_a : assert property (
		s_ctl_write ##0
		(I_PWDATA[7:2] == {POM_DEV_VAL, POM_SRC_DEV}) |=>
		##1 O_PIN4 == $past(I_PWDATA[POM_VAL_BIT], 2))
		else $error("written value not on pin in two cycles");

	drive_on_a : assert property (
		s_enable_write |=> ##1 !O_PIN4_DRV_N)
		else $error("driver not enabled after write");

	drive_track_a : assert property (
		1'b1 |=> O_PIN4_DRV_N == !$past(cfg.drive_en))
		else $error("driver enable does not follow bit");

	reset_clear_a : assert property (
		$fell(I_RST) |-> a_ctl == POM_CTL_RST && O_PIN4_DRV_N)
		else $error("control not cleared by reset");

	unmapped_a : assert property (
		I_PSEL && I_PENABLE && I_PADDR != POM_ADDR_CTL &&
		I_PADDR != POM_ADDR_STAT |-> O_PSLVERR && O_PREADY)
		else $error("unmapped access without error");

	// ------------------------------------------------------------
	// bus and pin path checks
	// ------------------------------------------------------------
	// control write qualifier and mapped address as plain terms
	wire       a_ctl_wr = I_PSEL && I_PENABLE && I_PWRITE &&
	                      (I_PADDR == POM_ADDR_CTL) && I_PSTRB[0];
	wire       a_mapped = (I_PADDR == POM_ADDR_CTL) ||
	                      (I_PADDR == POM_ADDR_STAT);

	sequence s_stat_read;
		I_PSEL && !I_PENABLE && !I_PWRITE && (I_PADDR == POM_ADDR_STAT)
		##1 I_PSEL && I_PENABLE;
	endsequence

	sequence s_disable_write;
		s_ctl_write and !I_PWDATA[POM_EN_BIT];
	endsequence

	// zero wait states
	ready_high_a : assert property (
		O_PREADY)
		else $error("pready not high");

	// mapped accesses answer without error
	mapped_no_err_a : assert property (
		I_PSEL && I_PENABLE && a_mapped |-> !O_PSLVERR)
		else $error("error on a mapped access");

	// no error outside the access phase
	err_idle_a : assert property (
		!(I_PSEL && I_PENABLE) |-> !O_PSLVERR)
		else $error("error outside the access phase");

	// status word returns the level and reserved flag
	stat_readback_a : assert property (
		s_stat_read |-> O_PRDATA == {30'h0, $past(cfg.rsv), $past(cfg.level)})
		else $error("status readback wrong");

	// read data holds between read setup cycles
	rdata_hold_a : assert property (
		!(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA))
		else $error("read data changed without a read");

	// control register changes only on a control write
	ctl_hold_a : assert property (
		!a_ctl_wr |=> $stable(a_ctl))
		else $error("control changed without a write");

	// reserved combinations never drive high
	rsv_low_a : assert property (
		cfg.rsv |-> !cfg.level)
		else $error("reserved combination not low");

	// receive port sources are never reserved
	rx_no_rsv_a : assert property (
		a_rx |-> !cfg.rsv)
		else $error("receive port source flagged reserved");

	// pin follows the mux one cycle later
	pin_track_a : assert property (
		1'b1 |=> O_PIN4 == $past(cfg.level))
		else $error("pin does not follow the mux");

	// driver off after a write that clears the enable bit
	drive_off_a : assert property (
		s_disable_write |=> ##1 O_PIN4_DRV_N)
		else $error("driver not disabled after write");

	// pin level low right after reset
	reset_pin_a : assert property (
		$fell(I_RST) |-> !O_PIN4)
		else $error("pin not low after reset");
endmodule

/* hdl/pom_pkg.sv */
// pom_pkg: register map, field layout and select codes of the pin 4
// output source mux.
// assumes a 32-bit APB slave with byte addresses in an 8-bit window.
package pom_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] POM_ADDR_CTL  = 8'h14; // pin4_output_control
	localparam logic [7:0] POM_ADDR_STAT = 8'h18; // mux status, read only

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int         POM_CTL_W     = 8;
	localparam int         POM_SEL_LO    = 5;
	localparam int         POM_SRC_LO    = 2;
	localparam int         POM_VAL_BIT   = 1;
	localparam int         POM_EN_BIT    = 0;
	localparam logic [7:0] POM_CTL_RST   = 8'h00;
	localparam int         POM_STAT_LVL  = 0;
	localparam int         POM_STAT_RSV  = 1;
	localparam logic       POM_PIN_RST   = 1'b0;
	localparam logic       POM_DRV_N_RST = 1'b1;
	localparam int         POM_NPORT     = 4;
	localparam int         POM_NRPIN     = 4;

	// ------------------------------------------------------------
	// source codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		POM_SRC_RX0  = 3'h0,
		POM_SRC_RX1  = 3'h1,
		POM_SRC_RX2  = 3'h2,
		POM_SRC_RX3  = 3'h3,
		POM_SRC_DEV  = 3'h4,
		POM_SRC_RSV5 = 3'h5,
		POM_SRC_TX0  = 3'h6,
		POM_SRC_RSV7 = 3'h7
	} pom_src_t;

	// ------------------------------------------------------------
	// signal select codes per source
	// ------------------------------------------------------------
	localparam logic [2:0] POM_RX_LOCK     = 3'h4;
	localparam logic [2:0] POM_RX_PASS     = 3'h5;
	localparam logic [2:0] POM_RX_FV       = 3'h6;
	localparam logic [2:0] POM_DEV_VAL     = 3'h0;
	localparam logic [2:0] POM_DEV_LOCK_OR = 3'h1;
	localparam logic [2:0] POM_DEV_PASS_A  = 3'h2;
	localparam logic [2:0] POM_DEV_PASS_B  = 3'h3;
	localparam logic [2:0] POM_DEV_FSYNC   = 3'h4;
	localparam logic [2:0] POM_TX_AND      = 3'h0;
	localparam logic [2:0] POM_TX_OR       = 3'h1;
	localparam logic [2:0] POM_TX_FRAME    = 3'h2;
	localparam logic [2:0] POM_TX_LINE     = 3'h3;
	localparam logic [2:0] POM_TX_SYNC     = 3'h4;
	localparam logic [2:0] POM_TX_IRQ      = 3'h5;

endpackage

/* hdl/pom_ctl_if.sv */
// pom_ctl_if: control fields and mux result between the register
// file, the source mux and the top.
// assumes one clock domain; the interface carries levels only.
interface pom_ctl_if;
	pom_pkg::pom_src_t src;       // source select field
	logic [2:0]        sel;       // signal select field
	logic              local_val; // software pin value
	logic              drive_en;  // output driver enable
	logic              level;     // selected signal level
	logic              rsv;       // reserved combination chosen

	modport regs (output src, sel, local_val, drive_en, input level, rsv);
	modport mux  (input src, sel, local_val, output level, rsv);
	modport mon  (input src, sel, local_val, drive_en, level, rsv);
endinterface

/* hdl/pom_regs.sv */
// pom_regs: APB slave holding the pin control and status registers.
// assumes an APB master that holds each request until pready.
module pom_regs import pom_pkg::*; (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	pom_ctl_if.regs          cfg
);
	logic [7:0] ctl;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire        hit_ctl  = (i_paddr == POM_ADDR_CTL);
	wire        hit_stat = (i_paddr == POM_ADDR_STAT);
	wire        setup    = i_psel & ~i_penable;
	wire        access   = i_psel & i_penable;
	wire        wr_ctl   = access & i_pwrite & hit_ctl & i_pstrb[0];
	wire [31:0] stat_word = {30'h0, cfg.rsv, cfg.level};
	wire [31:0] rd_mux   = hit_ctl  ? {24'h000000, ctl} :
	                       hit_stat ? stat_word : 32'h00000000;

	// zero wait states; unmapped addresses answer with an error
	assign o_pready  = 1'b1;
	assign o_pslverr = access & ~(hit_ctl | hit_stat);

	// field split of the control register
	assign cfg.sel       = ctl[POM_CTL_W-1:POM_SEL_LO];
	assign cfg.src       = pom_src_t'(ctl[POM_SEL_LO-1:POM_SRC_LO]);
	assign cfg.local_val = ctl[POM_VAL_BIT];
	assign cfg.drive_en  = ctl[POM_EN_BIT];

	// control register, all fields clear at reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctl <= POM_CTL_RST;
		end else if (wr_ctl) begin
			ctl <= i_pwdata[POM_CTL_W-1:0];
		end
	end

	// read data captured in the setup phase
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_prdata <= 32'h00000000;
		end else if (setup & ~i_pwrite) begin
			o_prdata <= rd_mux;
		end
	end
endmodule

/* hdl/pom_mux.sv */
// pom_mux: picks the pin level from the chosen source and signal.
// assumes all status inputs come from logic on the same clock.
module pom_mux import pom_pkg::*; (
	input  wire logic [15:0] i_rx_remote_pin,
	input  wire logic [3:0]  i_rx_lock,
	input  wire logic [3:0]  i_rx_pass,
	input  wire logic [3:0]  i_rx_frame_valid,
	input  wire logic [3:0]  i_rx_line_valid,
	input  wire logic [3:0]  i_rx_port_en,
	input  wire logic        i_frame_sync_pulse,
	input  wire logic [3:0]  i_tx_rx_sel,
	input  wire logic        i_tx_frame_active,
	input  wire logic        i_tx_line_active,
	input  wire logic        i_tx_synced,
	input  wire logic        i_tx_irq,
	pom_ctl_if.mux           cfg
);
	logic [POM_NPORT-1:0] port_val;

	// ------------------------------------------------------------
	// per receive port selection
	// ------------------------------------------------------------
	for (genvar p = 0; p < POM_NPORT; p++) begin : g_port
		wire [POM_NRPIN-1:0] rpin = i_rx_remote_pin[p*POM_NRPIN +: POM_NRPIN];
		wire                 stat = (cfg.sel == POM_RX_LOCK) ? i_rx_lock[p] :
		                            (cfg.sel == POM_RX_PASS) ? i_rx_pass[p] :
		                            (cfg.sel == POM_RX_FV) ?
		                            i_rx_frame_valid[p] : i_rx_line_valid[p];
		// upper codes: port status, lower: forwarded remote pins
		assign port_val[p] = cfg.sel[2] ? stat :
		                     rpin[cfg.sel[1:0]];
	end

	// ------------------------------------------------------------
	// device status and transmit port terms
	// ------------------------------------------------------------
	wire is_rx    = ~cfg.src[2];
	wire is_dev   = (cfg.src == POM_SRC_DEV);
	wire is_tx    = (cfg.src == POM_SRC_TX0);
	wire rx_level = port_val[cfg.src[1:0]];
	wire lock_or  = |(i_rx_lock & i_rx_port_en);
	wire pass_and = (|i_rx_port_en) & (&(i_rx_pass | ~i_rx_port_en));
	wire tx_and   = (|i_tx_rx_sel) & (&(i_rx_pass | ~i_tx_rx_sel));
	wire tx_or    = |(i_rx_pass & i_tx_rx_sel);

	// device status selection, reserved codes read low
	wire dev_level = (cfg.sel == POM_DEV_VAL) ? cfg.local_val :
	                 (cfg.sel == POM_DEV_LOCK_OR) ? lock_or :
	                 (cfg.sel == POM_DEV_PASS_A) ? pass_and :
	                 (cfg.sel == POM_DEV_PASS_B) ? pass_and :
	                 (cfg.sel == POM_DEV_FSYNC) ? i_frame_sync_pulse :
	                 1'b0;
	// transmit port selection, reserved codes read low
	wire tx_level = (cfg.sel == POM_TX_AND) ? tx_and :
	                (cfg.sel == POM_TX_OR) ? tx_or :
	                (cfg.sel == POM_TX_FRAME) ? i_tx_frame_active :
	                (cfg.sel == POM_TX_LINE) ? i_tx_line_active :
	                (cfg.sel == POM_TX_SYNC) ? i_tx_synced :
	                (cfg.sel == POM_TX_IRQ) ? i_tx_irq : 1'b0;

	// final source choice; reserved sources read low
	assign cfg.level = is_rx ? rx_level :
	                   is_dev ? dev_level :
	                   is_tx ? tx_level : 1'b0;
	assign cfg.rsv   = (~is_rx & ~is_dev & ~is_tx) |
	                   (is_dev & (cfg.sel > POM_DEV_FSYNC)) |
	                   (is_tx & (cfg.sel > POM_TX_IRQ));
endmodule

/* tb/pom_pin_sampler.sv */
// pom_pin_sampler: external logic sampling pin 4 of the device.
// assumes the pin has no pull resistor; released wire shows the
// inverse of the last driven level so stale values never match.
module pom_pin_sampler (
	input  wire logic i_clk,
	input  wire logic i_pin,
	input  wire logic i_drv_n,
	output logic      o_wire
);
	timeunit 1ns;
	timeprecision 1ps;

	logic last_lvl;

	// ------------------------------------------------------------
	// wire level seen by the sampling logic
	// ------------------------------------------------------------
	// remember what the device last drove
	always @(posedge i_clk) begin
		if (!i_drv_n) begin
			last_lvl <= i_pin;
		end
	end

	// released wire floats away from the last driven level
	assign o_wire = i_drv_n ? ~last_lvl : i_pin;
endmodule

/* tb/pin4_output_source_mux_test.sv */
// pin4_output_source_mux_test: register level bench of the pin 4
// output source mux, driving APB and every status input.
// assumes zero or more APB wait states and a registered pin path.
module pin4_output_source_mux_test;
	import pom_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, pin, drv_n, wire_lvl;
	logic [15:0] remote = 16'h0000;
	logic [3:0]  lock = 4'h0, pass = 4'h0, fv = 4'h0, lv = 4'h0;
	logic [3:0]  port_en = 4'h0, tx_sel = 4'h0;
	logic        fsync = 1'b0, tx_frame = 1'b0, tx_line = 1'b0;
	logic        tx_sync = 1'b0, tx_irq = 1'b0;
	logic [31:0] rd;
	logic        err, lvl, rsv, v, e;
	logic [2:0]  src, sel;
	logic [7:0]  ctl;
	int          n_fail = 0;
	int          checks_done = 0;

	// ------------------------------------------------------------
	// clock, design and pin sampler
	// ------------------------------------------------------------
	always #20 clk = ~clk;

	pom_top dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_REMOTE_PIN(remote),
		.I_RX_LOCK(lock), .I_RX_PASS(pass), .I_RX_FRAME_VALID(fv),
		.I_RX_LINE_VALID(lv), .I_RX_PORT_EN(port_en),
		.I_FRAME_SYNC_PULSE(fsync), .I_TX_RX_SEL(tx_sel),
		.I_TX_FRAME_ACTIVE(tx_frame), .I_TX_LINE_ACTIVE(tx_line),
		.I_TX_SYNCED(tx_sync), .I_TX_IRQ(tx_irq), .O_PIN4(pin),
		.O_PIN4_DRV_N(drv_n));

	pom_pin_sampler far_u (.i_clk(clk), .i_pin(pin), .i_drv_n(drv_n),
		.o_wire(wire_lvl));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	// compare and count
	task automatic check(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] wd, input logic [3:0] st,
			output logic [31:0] d, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= st;
		@(posedge clk);
		penable <= 1'b1;
		// the wait ends when pready is high, or at the watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		d = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// two status patterns: they flip every and/or outcome but the tx OR, which is high in both
	task automatic set_pat(input int k);
		remote <= (k == 0) ? 16'hA5C3 : 16'h5A3C;
		lock <= (k == 0) ? 4'h9 : 4'h2;
		pass <= (k == 0) ? 4'hD : 4'hB;
		fv <= (k == 0) ? 4'h5 : 4'hA;
		lv <= (k == 0) ? 4'hA : 4'h5;
		port_en <= (k == 0) ? 4'h6 : 4'h3;
		tx_sel <= (k == 0) ? 4'h5 : 4'h6;
		fsync <= (k == 0);
		tx_frame <= (k != 0);
		tx_line <= (k == 0);
		tx_sync <= (k != 0);
		tx_irq <= (k == 0);
	endtask

	// level the pin should carry, reserved codes give 0
	function automatic logic exp_level(input logic [2:0] s,
			input logic [2:0] g, input logic val);
		if (s[2] == 1'b0) begin
			case (g)
				3'h4: return lock[s[1:0]];
				3'h5: return pass[s[1:0]];
				3'h6: return fv[s[1:0]];
				3'h7: return lv[s[1:0]];
				default: return remote[{s[1:0], g[1:0]}];
			endcase
		end
		if (s == 3'h4) begin
			case (g)
				3'h0: return val;
				3'h1: return |(lock & port_en);
				3'h2, 3'h3: return port_en != 4'h0
					&& (pass & port_en) == port_en;
				3'h4: return fsync;
				default: return 1'b0;
			endcase
		end
		if (s == 3'h6) begin
			case (g)
				3'h0: return tx_sel != 4'h0 && (pass & tx_sel) == tx_sel;
				3'h1: return |(pass & tx_sel);
				3'h2: return tx_frame;
				3'h3: return tx_line;
				3'h4: return tx_sync;
				3'h5: return tx_irq;
				default: return 1'b0;
			endcase
		end
		return 1'b0;
	endfunction

	// verdict and end of run
	task close_out;
		if (n_fail == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("drv_n after reset", 32'h1, 32'(drv_n));
		check("pin after reset", 32'h0, 32'(pin));
		apb(1'b0, POM_ADDR_CTL, 32'h0, 4'h0, rd, err);
		check("ctl reset", 32'(POM_CTL_RST), rd);
		// every source and select code, both patterns
		for (int k = 0; k < 2; k++) begin
			for (int c = 0; c < 64; c++) begin
				set_pat(k);
				sel = 3'(c >> 3);
				src = 3'(c);
				v = c[0] ^ k[0];
				e = c[1] ^ k[0];
				ctl = {sel, src, v, e};
				apb(1'b1, POM_ADDR_CTL, {24'h000000, ctl}, 4'hF, rd, err);
				repeat (2) @(posedge clk);
				lvl = exp_level(src, sel, v);
				rsv = src == 3'h5 || src == 3'h7 || (src == 3'h4 && sel > 3'h4)
					|| (src == 3'h6 && sel > 3'h5);
				// pin level per code
				check("pin level", 32'(lvl), 32'(pin));
				check("drv_n", 32'(!e), 32'(drv_n));
				if (e) check("wire", 32'(lvl), 32'(wire_lvl));
				apb(1'b0, POM_ADDR_CTL, 32'h0, 4'h0, rd, err);
				check("ctl readback", {24'h000000, ctl}, rd);
				check("ctl read err", 32'h0, 32'(err));
				apb(1'b0, POM_ADDR_STAT, 32'h0, 4'h0, rd, err);
				check("status", {30'h0, rsv, lvl}, rd);
			end
		end
		// refused writes leave the control register alone
		apb(1'b1, 8'h40, 32'h000000FF, 4'hF, rd, err);
		check("unmapped write err", 32'h1, 32'(err));
		apb(1'b1, POM_ADDR_STAT, 32'h000000FF, 4'hF, rd, err);
		check("status write err", 32'h0, 32'(err));
		apb(1'b1, POM_ADDR_CTL, 32'h000000FF, 4'h0, rd, err);
		apb(1'b0, 8'h40, 32'h0, 4'h0, rd, err);
		check("unmapped read err", 32'h1, 32'(err));
		check("unmapped read data", 32'h0, rd);
		apb(1'b0, POM_ADDR_CTL, 32'h0, 4'h0, rd, err);
		check("ctl kept", {24'h000000, ctl}, rd);
		// reset in mid-run clears the enabled register
		apb(1'b1, POM_ADDR_CTL, 32'h00000093, 4'hF, rd, err);
		repeat (2) @(posedge clk);
		check("drv_n before reset", 32'h0, 32'(drv_n));
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("drv_n after reset 2", 32'h1, 32'(drv_n));
		apb(1'b0, POM_ADDR_CTL, 32'h0, 4'h0, rd, err);
		check("ctl reset 2", 32'h0, rd);
		close_out();
	end

	// watchdog: the tests need about 1450 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule
